//--- design/tfc_pkg.sv
package tfc_pkg;

	// ------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------
	localparam int SITES = 2;
	localparam int CNT_W = 16;
	localparam int GPIO_W = 8;
	localparam int COND_W = 2;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 25000;
	// Least width of a capture or edge-type duplex strobe.
	localparam int STROBE_NS = 100;
	localparam int STROBE_CYC_RAW =
		(STROBE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int STROBE_CYC = (STROBE_CYC_RAW < 1) ? 1 : STROBE_CYC_RAW;
	localparam int SYNC_STAGES = 3;

	// ------------------------------------------------------------
	// Values after reset
	// ------------------------------------------------------------
	localparam logic RST_N_RESET = 1'b0;
	localparam logic IRQ_RESET = 1'b0;
	localparam logic STROBE_RESET = 1'b0;
	localparam logic REV_RESET = 1'b0;
	localparam logic [GPIO_W-1:0] GPIO_OE_RESET = 8'h00;
	localparam logic [GPIO_W-1:0] GPIO_OUT_RESET = 8'h00;

endpackage : tfc_pkg

//--- design/tfc_sync.sv
`timescale 1ns/1ps
module tfc_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Asynchronous input and filtered result
	input wire logic [WIDTH-1:0] async_i,
	input wire logic [WIDTH-1:0] reset_value_i,
	output logic [WIDTH-1:0] sync_o
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] val;
		logic [1:0] fill;
	} tfc_sync_s;

	tfc_sync_s st_q;
	tfc_sync_s st_d;

	if (WIDTH < 1)
	begin : g_chk
		$error("tfc_sync: WIDTH must be at least one");
	end

	// A bit only moves once stages two and three agree, so a single
	// metastable sample never reaches the logic. The first stage feeds
	// the second only. Stages two and three still hold reset zeros for
	// three clocks after release, so the filter waits for the fill count;
	// until then the output shows the given value, also during reset.
	always_comb
	begin
		st_d = st_q;
		st_d.s1 = async_i;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		if (st_q.fill != 2'h3)
		begin
			st_d.fill = st_q.fill + 2'h1;
			st_d.val = reset_value_i;
		end
		else
		begin
			for (int i = 0; i < WIDTH; i++)
			begin
				if (st_q.s2[i] == st_q.s3[i])
				begin
					st_d.val[i] = st_q.s3[i];
				end
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			st_q <= '0;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	assign sync_o = (st_q.fill == 2'h0) ? reset_value_i : st_q.val;

endmodule : tfc_sync

//--- design/tfc_top.sv
// Behaviour
// - A rising transmit-capture strobe marks downlink time for the card.
// - A rising receive-capture strobe marks uplink time for the card.
// - Original revision: one receive-on rise starts uplink, ends downlink.
// - Later revision: receive-on is high for the whole uplink window.
// - Original revision: a transmit-on rising edge starts each downlink.
// - Later revision: transmit-on is high for the whole downlink window.
// - Receive-off rises at uplink end on the original revision only.
// - A timed power-amplifier enable event is driven from the schedule.
// - A timed antenna-switch event follows the duplex schedule.
// - An active-high interrupt line is driven toward the card.
// - An active-low reset holds the front-end chip in reset while low.
// - Each site has an eight-bit later-revision bank, per-bit direction.
// - Each site has a further eight-bit general bank, per-bit direction.
`timescale 1ns/1ps
module tfc_top #(
	parameter int SITES = tfc_pkg::SITES,
	parameter int CNT_W = tfc_pkg::CNT_W
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Schedule control, per site
	input wire logic [SITES-1:0] site_enable_i,
	input wire logic [SITES-1:0] revised_card_i,
	input wire logic [SITES-1:0][CNT_W-1:0] frame_len_i,
	input wire logic [SITES-1:0][CNT_W-1:0] tx_start_i,
	input wire logic [SITES-1:0][CNT_W-1:0] tx_stop_i,
	input wire logic [SITES-1:0][CNT_W-1:0] rx_start_i,
	input wire logic [SITES-1:0][CNT_W-1:0] rx_stop_i,
	input wire logic [SITES-1:0][CNT_W-1:0] pa_start_i,
	input wire logic [SITES-1:0][CNT_W-1:0] pa_stop_i,
	// Card control requests, per site
	input wire logic [SITES-1:0] irq_request_i,
	input wire logic [SITES-1:0] reset_request_i,
	// General-purpose bank control, per site
	input wire logic [SITES-1:0][7:0] revised_io_out_i,
	input wire logic [SITES-1:0][7:0] revised_io_dir_i,
	input wire logic [SITES-1:0][7:0] general_io_out_i,
	input wire logic [SITES-1:0][7:0] general_io_dir_i,
	// Card pins in
	input wire logic [SITES-1:0] frontend_busy_n_i,
	input wire logic [SITES-1:0][1:0] frontend_condition_in_i,
	input wire logic [SITES-1:0][7:0] revised_card_io_bank_i,
	input wire logic [SITES-1:0][7:0] site_general_io_bank_i,
	// Card pins out
	output logic [SITES-1:0] transmit_capture_strobe_o,
	output logic [SITES-1:0] receive_capture_strobe_o,
	output logic [SITES-1:0] receive_on_strobe_o,
	output logic [SITES-1:0] transmit_on_strobe_o,
	output logic [SITES-1:0] receive_off_strobe_o,
	output logic [SITES-1:0] power_amp_enable_event_o,
	output logic [SITES-1:0] antenna_switch_event_o,
	output logic [SITES-1:0] frontend_interrupt_out_o,
	output logic [SITES-1:0] frontend_reset_n_o,
	output logic [SITES-1:0][7:0] revised_card_io_bank_o,
	output logic [SITES-1:0][7:0] revised_card_io_bank_oe_o,
	output logic [SITES-1:0][7:0] site_general_io_bank_o,
	output logic [SITES-1:0][7:0] site_general_io_bank_oe_o,
	// Status toward local logic
	output logic [SITES-1:0] frontend_busy_o,
	output logic [SITES-1:0] serial_start_ok_o,
	output logic [SITES-1:0][1:0] frontend_condition_o,
	output logic [SITES-1:0][7:0] revised_io_in_o,
	output logic [SITES-1:0][7:0] general_io_in_o,
	output logic [SITES-1:0] frame_start_o
);

	// ------------------------------------------------------------
	// Checks and types
	// ------------------------------------------------------------
	// One site's pins in the synchroniser vector, busy on top.
	localparam int PIN_W = 1 + 2 + 8 + 8;
	localparam int BUSY_AT = PIN_W - 1;
	localparam int COND_AT = 16;
	localparam int REV_AT = 8;
	localparam int SYNC_W = SITES * PIN_W;

	if (SITES < 1 || CNT_W < 4 || CNT_W > 31)
	begin : g_chk
		$error("tfc_top: SITES must be >= 1 and CNT_W in 4..31");
	end

	// A strobe as long as the whole count range could never end.
	if (CNT_W < 31 && tfc_pkg::STROBE_CYC >= (1 << CNT_W))
	begin : g_chk_strobe
		$error("tfc_top: strobe width exceeds the count range");
	end

	typedef struct packed {
		logic [SITES-1:0][CNT_W-1:0] cnt;
		logic [SITES-1:0] run;
		logic [SITES-1:0] rev;
		logic [SITES-1:0] fstart;
		logic [SITES-1:0] tx_cap;
		logic [SITES-1:0] rx_cap;
		logic [SITES-1:0] rx_on;
		logic [SITES-1:0] tx_on;
		logic [SITES-1:0] rx_off;
		logic [SITES-1:0] pa;
		logic [SITES-1:0] ant;
		logic [SITES-1:0] irq;
		logic [SITES-1:0] rst_n;
		logic [SITES-1:0][7:0] rgp_out;
		logic [SITES-1:0][7:0] rgp_oe;
		logic [SITES-1:0][7:0] ggp_out;
		logic [SITES-1:0][7:0] ggp_oe;
	} tfc_state_s;

	tfc_state_s st_q;
	tfc_state_s st_d;

	logic [SYNC_W-1:0] sync_raw;
	logic [SYNC_W-1:0] sync_init;
	logic [SYNC_W-1:0] sync_val;

	// ------------------------------------------------------------
	// Window helpers
	// ------------------------------------------------------------
	// Level window [a, b); an empty window when b <= a.
	function automatic logic in_win(
		input logic [CNT_W-1:0] c,
		input logic [CNT_W-1:0] a,
		input logic [CNT_W-1:0] b
	);
		return (c >= a) && (c < b);
	endfunction : in_win

	// Strobe of STROBE_CYC cycles that starts when the count reaches a.
	// The end is one bit wider so a strobe near the top cannot wrap.
	function automatic logic in_pulse(
		input logic [CNT_W-1:0] c,
		input logic [CNT_W-1:0] a
	);
		logic [CNT_W:0] e;
		e = {1'b0, a} + (CNT_W+1)'(tfc_pkg::STROBE_CYC);
		return (c >= a) && ({1'b0, c} < e);
	endfunction : in_pulse

	// ------------------------------------------------------------
	// Pin input synchronisers
	// ------------------------------------------------------------
	for (genvar s = 0; s < SITES; s++)
	begin : g_pins
		logic [PIN_W-1:0] site_pins;
		assign sync_raw[s*PIN_W +: PIN_W] = {
			frontend_busy_n_i[s],
			frontend_condition_in_i[s],
			revised_card_io_bank_i[s],
			site_general_io_bank_i[s]
		};
		// Busy reads idle-high until the pipe fills, to avoid a false busy.
		assign sync_init[s*PIN_W +: PIN_W] = {1'b1, {(PIN_W-1){1'b0}}};
		assign site_pins = sync_val[s*PIN_W +: PIN_W];
		assign frontend_busy_o[s] = ~site_pins[BUSY_AT];
		assign frontend_condition_o[s] = site_pins[COND_AT +: 2];
		assign revised_io_in_o[s] = site_pins[REV_AT +: 8];
		assign general_io_in_o[s] = site_pins[7:0];
		// A card held in reset cannot take a serial operation either.
		assign serial_start_ok_o[s] = site_pins[BUSY_AT] & st_q.rst_n[s];
	end

	tfc_sync #(
		.WIDTH(SYNC_W)
	) u_sync (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.async_i(sync_raw),
		.reset_value_i(sync_init),
		.sync_o(sync_val)
	);

	// ------------------------------------------------------------
	// Per-site duplex schedule
	// ------------------------------------------------------------
	// A window or strobe that reaches past the frame length is cut at the
	// frame end, as the count wraps before it closes. Window edges and the
	// frame length are read live, so a change lands on the next cycle, even in mid-frame.
	always_comb
	begin
		logic act;
		logic rev;
		logic dl;
		logic ul;
		logic [CNT_W-1:0] c;
		logic [CNT_W:0] nxt;
		act = 1'b0;
		rev = 1'b0;
		dl = 1'b0;
		ul = 1'b0;
		c = '0;
		nxt = '0;
		st_d = st_q;
		for (int s = 0; s < SITES; s++)
		begin
			// Frame counter; the card revision is taken at each frame
			// start so a strobe never changes meaning mid-frame.
			c = st_q.cnt[s];
			nxt = {1'b0, c} + {{CNT_W{1'b0}}, 1'b1};
			st_d.fstart[s] = 1'b0;
			if (!site_enable_i[s])
			begin
				st_d.run[s] = 1'b0;
				st_d.cnt[s] = '0;
			end
			else if (!st_q.run[s] || nxt >= {1'b0, frame_len_i[s]})
			begin
				st_d.run[s] = 1'b1;
				st_d.cnt[s] = '0;
				st_d.rev[s] = revised_card_i[s];
				st_d.fstart[s] = 1'b1;
			end
			else
			begin
				st_d.cnt[s] = nxt[CNT_W-1:0];
			end

			act = st_q.run[s];
			rev = st_q.rev[s];
			dl = act && in_win(c, tx_start_i[s], tx_stop_i[s]);
			ul = act && in_win(c, rx_start_i[s], rx_stop_i[s]);

			st_d.tx_cap[s] = act && in_pulse(c, tx_start_i[s]);
			st_d.rx_cap[s] = act && in_pulse(c, rx_start_i[s]);
			if (rev)
			begin
				st_d.rx_on[s] = ul;
				st_d.tx_on[s] = dl;
				st_d.rx_off[s] = 1'b0;
			end
			else
			begin
				// Receive-on also closes the downlink here.
				st_d.rx_on[s] = act && in_pulse(c, rx_start_i[s]);
				st_d.tx_on[s] = act && in_pulse(c, tx_start_i[s]);
				st_d.rx_off[s] = act && in_pulse(c, rx_stop_i[s]);
			end
			st_d.pa[s] = act && in_win(c, pa_start_i[s], pa_stop_i[s]);
			// High selects the transmit path, low the receive path.
			st_d.ant[s] = dl;

			st_d.irq[s] = irq_request_i[s];
			st_d.rst_n[s] = ~reset_request_i[s];

			st_d.rgp_out[s] = revised_io_out_i[s];
			st_d.rgp_oe[s] = revised_io_dir_i[s];
			st_d.ggp_out[s] = general_io_out_i[s];
			st_d.ggp_oe[s] = general_io_dir_i[s];
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			st_q.cnt <= '0;
			st_q.run <= '0;
			st_q.rev <= {SITES{tfc_pkg::REV_RESET}};
			st_q.fstart <= '0;
			st_q.tx_cap <= {SITES{tfc_pkg::STROBE_RESET}};
			st_q.rx_cap <= {SITES{tfc_pkg::STROBE_RESET}};
			st_q.rx_on <= {SITES{tfc_pkg::STROBE_RESET}};
			st_q.tx_on <= {SITES{tfc_pkg::STROBE_RESET}};
			st_q.rx_off <= {SITES{tfc_pkg::STROBE_RESET}};
			st_q.pa <= {SITES{tfc_pkg::STROBE_RESET}};
			st_q.ant <= {SITES{tfc_pkg::STROBE_RESET}};
			st_q.irq <= {SITES{tfc_pkg::IRQ_RESET}};
			// The card chip stays in reset until the logic runs.
			st_q.rst_n <= {SITES{tfc_pkg::RST_N_RESET}};
			st_q.rgp_out <= {SITES{tfc_pkg::GPIO_OUT_RESET}};
			st_q.rgp_oe <= {SITES{tfc_pkg::GPIO_OE_RESET}};
			st_q.ggp_out <= {SITES{tfc_pkg::GPIO_OUT_RESET}};
			st_q.ggp_oe <= {SITES{tfc_pkg::GPIO_OE_RESET}};
		end
		else
		begin
			st_q <= st_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign transmit_capture_strobe_o = st_q.tx_cap;
	assign receive_capture_strobe_o = st_q.rx_cap;
	assign receive_on_strobe_o = st_q.rx_on;
	assign transmit_on_strobe_o = st_q.tx_on;
	assign receive_off_strobe_o = st_q.rx_off;
	assign power_amp_enable_event_o = st_q.pa;
	assign antenna_switch_event_o = st_q.ant;
	assign frontend_interrupt_out_o = st_q.irq;
	assign frontend_reset_n_o = st_q.rst_n;
	assign revised_card_io_bank_o = st_q.rgp_out;
	assign revised_card_io_bank_oe_o = st_q.rgp_oe;
	assign site_general_io_bank_o = st_q.ggp_out;
	assign site_general_io_bank_oe_o = st_q.ggp_oe;
	assign frame_start_o = st_q.fstart;

endmodule : tfc_top

//--- testbench/tfc_props.sv
`timescale 1ns/1ps
module tfc_props #(
	parameter int SITES = 2,
	parameter int CNT_W = 16
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Requests
	input wire logic [SITES-1:0] site_enable_i,
	input wire logic [SITES-1:0] revised_card_i,
	input wire logic [SITES-1:0] irq_request_i,
	input wire logic [SITES-1:0] reset_request_i,
	// Card pins and status
	input wire logic [SITES-1:0] transmit_capture_strobe_o,
	input wire logic [SITES-1:0] receive_capture_strobe_o,
	input wire logic [SITES-1:0] receive_on_strobe_o,
	input wire logic [SITES-1:0] transmit_on_strobe_o,
	input wire logic [SITES-1:0] receive_off_strobe_o,
	input wire logic [SITES-1:0] antenna_switch_event_o,
	input wire logic [SITES-1:0] frontend_interrupt_out_o,
	input wire logic [SITES-1:0] frontend_reset_n_o,
	input wire logic [SITES-1:0] frontend_busy_o,
	input wire logic [SITES-1:0] serial_start_ok_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	a_irq_follow: assert property (
		$past(rst_n_i) |-> frontend_interrupt_out_o == $past(irq_request_i))
		else $error("interrupt lag wrong");
	a_reset_follow: assert property (
		$past(rst_n_i) |-> frontend_reset_n_o == ~$past(reset_request_i))
		else $error("card reset lag wrong");
	// Enable loss cuts strobes short, so those checks pause while it is low.
	a_txcap_width: assert property (
		disable iff (!rst_n_i || !site_enable_i[0])
		$rose(transmit_capture_strobe_o[0]) |->
		transmit_capture_strobe_o[0] [*4] ##1 !transmit_capture_strobe_o[0])
		else $error("tx capture width wrong");
	a_rxcap_width: assert property (
		disable iff (!rst_n_i || !site_enable_i[0])
		$rose(receive_capture_strobe_o[0]) |=>
		$stable(receive_capture_strobe_o[0]) [*3] ##1
		$fell(receive_capture_strobe_o[0]))
		else $error("rx capture width wrong");
	a_rxon_pulse: assert property (
		disable iff (!rst_n_i || !site_enable_i[0])
		!revised_card_i[0] && $rose(receive_on_strobe_o[0]) |->
		##4 $fell(receive_on_strobe_o[0]))
		else $error("receive-on pulse wrong");
	a_antenna_switch_event_level: assert property (
		revised_card_i[0] |->
		transmit_on_strobe_o[0] == antenna_switch_event_o[0])
		else $error("transmit-on window wrong");
	a_rxoff_idle: assert property (
		revised_card_i[0] |-> !receive_off_strobe_o[0])
		else $error("receive-off not idle");
	a_busy_block: assert property (
		frontend_busy_o[0] || !frontend_reset_n_o[0] |-> !serial_start_ok_o[0])
		else $error("start allowed while busy");
	cover property ($rose(transmit_capture_strobe_o[0]));
	cover property (revised_card_i[0] && transmit_on_strobe_o[0]);
	cover property (frontend_busy_o[1] && serial_start_ok_o[0]);
endmodule : tfc_props

bind tfc_top tfc_props #(.SITES(SITES), .CNT_W(CNT_W)) u_props (
	.clk_i, .rst_n_i, .site_enable_i, .revised_card_i, .irq_request_i,
	.reset_request_i, .transmit_capture_strobe_o, .receive_capture_strobe_o,
	.receive_on_strobe_o, .transmit_on_strobe_o, .receive_off_strobe_o,
	.antenna_switch_event_o, .frontend_interrupt_out_o, .frontend_reset_n_o,
	.frontend_busy_o, .serial_start_ok_o
);

//--- testbench/tfc_card_model.sv
`timescale 1ns/1ps
module tfc_card_model #(
	parameter int BUSY_CYC = 12
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Device side
	input wire logic [1:0] reset_n_i,
	input wire logic [1:0] kick_i,
	input wire logic [15:0] rv_d_i,
	input wire logic [15:0] rv_oe_i,
	input wire logic [15:0] gn_d_i,
	input wire logic [15:0] gn_oe_i,
	// Card pins
	output logic [1:0] busy_n_o,
	output logic [3:0] cond_o,
	output logic [15:0] rv_pin_o,
	output logic [15:0] gn_pin_o
);
	logic [1:0][3:0] cnt_q;

	always_ff @(posedge clk_i or negedge rst_n_i)
		for (int s = 0; s < 2; s++)
			if (!rst_n_i)
				cnt_q[s] <= 4'h0;
			else if (!reset_n_i[s] || kick_i[s])
				cnt_q[s] <= 4'(BUSY_CYC);
			else if (cnt_q[s] != 4'h0)
				cnt_q[s] <= cnt_q[s] - 4'h1;
	always_comb
		for (int s = 0; s < 2; s++)
		begin
			busy_n_o[s] = cnt_q[s] == 4'h0;
			cond_o[2*s +: 2] = reset_n_i[s] ? 2'h1 : 2'h2;
		end
	// Undriven bits carry the card's own pattern, never a stale device value.
	assign rv_pin_o = (rv_oe_i & rv_d_i) | (~rv_oe_i & 16'hc35a);
	assign gn_pin_o = (gn_oe_i & gn_d_i) | (~gn_oe_i & 16'ha53c);
endmodule : tfc_card_model

//--- testbench/tdd_frontend_control_tb.sv
`timescale 1ns/1ps
module tdd_frontend_control_tb;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [1:0] site_enable_i, revised_card_i, irq_request_i, kick;
	logic [1:0] reset_request_i, frontend_busy_n_i, frame_start_o;
	logic [1:0][15:0] frame_len_i, tx_start_i, tx_stop_i, rx_start_i;
	logic [1:0][15:0] rx_stop_i, pa_start_i, pa_stop_i;
	logic [1:0][7:0] revised_io_out_i, revised_io_dir_i, general_io_out_i;
	logic [1:0][7:0] general_io_dir_i, revised_card_io_bank_i;
	logic [1:0][1:0] frontend_condition_in_i, frontend_condition_o;
	logic [1:0][7:0] site_general_io_bank_i, revised_io_in_o, general_io_in_o;
	logic [1:0] transmit_capture_strobe_o, receive_capture_strobe_o;
	logic [1:0] receive_on_strobe_o, transmit_on_strobe_o;
	logic [1:0] receive_off_strobe_o, power_amp_enable_event_o;
	logic [1:0] antenna_switch_event_o, frontend_interrupt_out_o;
	logic [1:0] frontend_reset_n_o, frontend_busy_o, serial_start_ok_o;
	logic [1:0][7:0] revised_card_io_bank_o, revised_card_io_bank_oe_o;
	logic [1:0][7:0] site_general_io_bank_o, site_general_io_bank_oe_o;
	int bad_count = 0;
	int total_checks = 0;
	logic [6:0] seen_v, exp_v;
	logic [15:0] fs_exp;

	always #12.5 clk_i = ~clk_i;

	tfc_top uut (
		.clk_i, .rst_n_i, .site_enable_i, .revised_card_i, .frame_len_i,
		.tx_start_i, .tx_stop_i, .rx_start_i, .rx_stop_i, .pa_start_i,
		.pa_stop_i, .irq_request_i, .reset_request_i, .revised_io_out_i,
		.revised_io_dir_i, .general_io_out_i, .general_io_dir_i,
		.frontend_busy_n_i, .frontend_condition_in_i, .revised_card_io_bank_i,
		.site_general_io_bank_i, .transmit_capture_strobe_o,
		.receive_capture_strobe_o, .receive_on_strobe_o, .transmit_on_strobe_o,
		.receive_off_strobe_o, .power_amp_enable_event_o,
		.antenna_switch_event_o, .frontend_interrupt_out_o, .frontend_reset_n_o,
		.revised_card_io_bank_o, .revised_card_io_bank_oe_o,
		.site_general_io_bank_o, .site_general_io_bank_oe_o, .frontend_busy_o,
		.serial_start_ok_o, .frontend_condition_o, .revised_io_in_o,
		.general_io_in_o, .frame_start_o
	);
	tfc_card_model card (
		.clk_i, .rst_n_i, .reset_n_i(frontend_reset_n_o), .kick_i(kick),
		.rv_d_i(revised_card_io_bank_o), .rv_oe_i(revised_card_io_bank_oe_o),
		.gn_d_i(site_general_io_bank_o), .gn_oe_i(site_general_io_bank_oe_o),
		.busy_n_o(frontend_busy_n_i), .cond_o(frontend_condition_in_i),
		.rv_pin_o(revised_card_io_bank_i), .gn_pin_o(site_general_io_bank_i)
	);

	task automatic check(input string n, input logic [15:0] v, e);
		total_checks++;
		if (v !== e)
		begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", n, e, v);
		end
	endtask : check

	task automatic step(input int n);
		repeat (n) @(posedge clk_i);
		#2;
	endtask : step

	task automatic close_out();
		if (bad_count == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : close_out

	function automatic logic [6:0] seen(input int s);
		return {transmit_capture_strobe_o[s], receive_capture_strobe_o[s],
			receive_on_strobe_o[s], transmit_on_strobe_o[s],
			receive_off_strobe_o[s], power_amp_enable_event_o[s],
			antenna_switch_event_o[s]};
	endfunction : seen

	function automatic logic [6:0] expv(input int s, j, input logic r);
		logic pt, pr, po, wt, wr, wp;
		pt = j >= tx_start_i[s] && j < tx_start_i[s] + tfc_pkg::STROBE_CYC;
		pr = j >= rx_start_i[s] && j < rx_start_i[s] + tfc_pkg::STROBE_CYC;
		po = j >= rx_stop_i[s] && j < rx_stop_i[s] + tfc_pkg::STROBE_CYC;
		wt = j >= tx_start_i[s] && j < tx_stop_i[s];
		wr = j >= rx_start_i[s] && j < rx_stop_i[s];
		wp = j >= pa_start_i[s] && j < pa_stop_i[s];
		return {pt, pr, r ? wr : pr, r ? wt : pt, !r && po, wp, wt};
	endfunction : expv

	initial
	begin
		site_enable_i = '0;
		revised_card_i = '0;
		irq_request_i = '0;
		reset_request_i = 2'h3;
		kick = '0;
		frame_len_i = {16'h0018, 16'h0018};
		tx_start_i = {16'h0005, 16'h0002};
		tx_stop_i = {16'h0009, 16'h0007};
		rx_start_i = {16'h000f, 16'h000c};
		rx_stop_i = {16'h0014, 16'h0014};
		// Site one's power window is reversed and must stay quiet.
		pa_start_i = {16'h000b, 16'h0001};
		pa_stop_i = {16'h0003, 16'h0009};
		revised_io_out_i = 16'h9669;
		revised_io_dir_i = 16'hf00f;
		general_io_out_i = 16'h8118;
		general_io_dir_i = 16'h33cc;
		repeat (4) @(posedge clk_i);
		#2 rst_n_i = 1'b1;
		check("card reset", 16'(frontend_reset_n_o), 16'h0000);
		step(10);
		check("busy", 16'({frontend_busy_o, serial_start_ok_o}), 16'h000c);
		check("condition", 16'(frontend_condition_o), 16'h000a);
		irq_request_i = 2'h1;
		reset_request_i = 2'h0;
		step(1);
		check("interrupt", 16'(frontend_interrupt_out_o), 16'h0001);
		check("card reset", 16'(frontend_reset_n_o), 16'h0003);
		check("rev out", revised_card_io_bank_o, revised_io_out_i);
		check("rev oe", revised_card_io_bank_oe_o, revised_io_dir_i);
		check("gen out", site_general_io_bank_o, general_io_out_i);
		check("gen oe", site_general_io_bank_oe_o, general_io_dir_i);
		irq_request_i = 2'h2;
		step(24);
		check("interrupt", 16'(frontend_interrupt_out_o), 16'h0002);
		check("idle", 16'({frontend_busy_o, serial_start_ok_o}), 16'h0003);
		check("condition", 16'(frontend_condition_o), 16'h0005);
		check("rev in", revised_io_in_o, (revised_io_dir_i & revised_io_out_i)
			| (~revised_io_dir_i & 16'hc35a));
		check("gen in", general_io_in_o, (general_io_dir_i & general_io_out_i)
			| (~general_io_dir_i & 16'ha53c));
		kick = 2'h2;
		step(1);
		kick = '0;
		step(7);
		check("busy", 16'({frontend_busy_o, serial_start_ok_o}), 16'h0009);
		for (int r = 0; r < 2; r++)
		begin
			revised_card_i = {~r[0], r[0]};
			site_enable_i = 2'h3;
			while (frame_start_o !== 2'h3)
				step(1);
			for (int j = 0; j < 48; j++)
			begin
				step(1);
				// The count wraps to zero, and frame start pulses, after 23.
				fs_exp = (j % 24 == 23) ? 16'h0003 : 16'h0000;
				check("frame start", 16'(frame_start_o), fs_exp);
				for (int s = 0; s < 2; s++)
				begin
					seen_v = seen(s);
					exp_v = expv(s, j % 24, r[0] ^ s[0]);
					check("tx capture", 16'(seen_v[6]), 16'(exp_v[6]));
					check("rx capture", 16'(seen_v[5]), 16'(exp_v[5]));
					check("receive on", 16'(seen_v[4]), 16'(exp_v[4]));
					check("transmit on", 16'(seen_v[3]), 16'(exp_v[3]));
					check("receive off", 16'(seen_v[2]), 16'(exp_v[2]));
					check("power amp", 16'(seen_v[1]), 16'(exp_v[1]));
					check("antenna", 16'(seen_v[0]), 16'(exp_v[0]));
				end
			end
			site_enable_i = '0;
			step(3);
		end
		close_out();
	end

	initial
	begin
		repeat (3000) @(posedge clk_i);
		bad_count++;
		close_out();
	end
endmodule : tdd_frontend_control_tb
